// ### tsfoc_link_partner.sv
`timescale 1ns/1ps
// ****************************************
// pcm frame source and payload source
// ****************************************
module tsfoc_link_partner (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic fire,
   input wire logic pay_req,
   output logic pcm_frame,
   output logic pay_bit
);
   logic [7:0] cnt;
   logic [2:0] hold;
   // payload pattern restarts per frame, so frames repeat exactly
   always_ff @(posedge clk) begin
      if (!rst_b || fire) cnt <= 8'h00;
      else if (pay_req) cnt <= cnt + 8'h01;
   end
   always_ff @(posedge clk) begin
      if (!rst_b) hold <= 3'h0;
      else if (fire) hold <= 3'h4;
      else if (hold != 3'h0) hold <= hold - 3'h1;
   end
   assign pay_bit = cnt[0] ^ cnt[2] ^ cnt[5];
   assign pcm_frame = (hold != 3'h0);
endmodule

// ### tsfoc_pkg.sv
package tsfoc_pkg;
   // ****************************************
   // register indices, byte address is four times the index
   // ****************************************
   localparam logic [9:0] IDX_SIG_PORT = 10'h084;
   localparam logic [9:0] IDX_START_DELAY = 10'h085;
   localparam logic [9:0] IDX_CMD_ONE = 10'h086;
   localparam logic [9:0] IDX_CMD_TWO = 10'h087;
   localparam logic [9:0] IDX_CMD_COMMON = 10'h0C0;
   localparam logic [9:0] IDX_PTR_RST = 10'h0D5;
   localparam logic [9:0] IDX_COPY_TRIG = 10'h0DB;
   localparam logic [9:0] IDX_TX_STATUS = 10'h0F8;
   // ****************************************
   // fields and reset values
   // ****************************************
   localparam int CMD1_SCRAM = 0;
   localparam int CMD1_CRC_INJ = 1;
   localparam int CMD1_OVH_EN = 2;
   localparam int CMD1_FORCE_ONES = 3;
   localparam int CMD1_SIG_TEST = 4;
   localparam int CMD2_TAP = 1;
   localparam int CMD2_NSB_LSB = 2;
   localparam int COMMON_RATE_LSB = 3;
   localparam logic [7:0] RST_START_DELAY = 8'h00;
   localparam logic [5:0] RST_CMD_ONE = 6'h00;
   localparam logic [7:0] RST_CMD_TWO = 8'h00;
   localparam logic [7:0] RST_CMD_COMMON = 8'h00;
   // ****************************************
   // sizes and timing
   // ****************************************
   localparam int SIG_DEPTH = 48;
   localparam int CRC_LEN = 6;
   localparam int SYNC_LEN = 14;
   localparam int SCR_LEN = 23;
   localparam int TAP_LOW = 5;
   localparam int TAP_HIGH = 18;
   localparam int FRAME_TIME_NS = 6000000;
   localparam int CLK_PERIOD_NS = 4;
   localparam int FRAME_CYCLES = FRAME_TIME_NS / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_DELAY = 3'h1,
      ST_SYNC = 3'h3,
      ST_CRC = 3'h2,
      ST_SIG = 3'h6,
      ST_PAY = 3'h7
   } tsfoc_state_type;

   // crc polynomial x^6 + x + 1, one bit per call
   function automatic logic [5:0] tsfoc_crc6(input logic [5:0] crc, input logic din);
      logic fb;
      fb = crc[5] ^ din;
      return {crc[4:1], crc[0] ^ fb, fb};
   endfunction
endpackage

// ### tsfoc_scrambler.sv
`timescale 1ns/1ps
module tsfoc_scrambler (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic advance,
   input wire logic enable,
   input wire logic tap_sel,
   input wire logic in_bit,
   output logic out_bit
);
   import tsfoc_pkg::*;
   logic [SCR_LEN-1:0] sreg;
   logic tap_bit;

   // self-synchronising, taps 5 or 18 of 23
   assign tap_bit = tap_sel ? sreg[TAP_HIGH-1] : sreg[TAP_LOW-1];
   assign out_bit = enable ? (in_bit ^ sreg[SCR_LEN-1] ^ tap_bit) : in_bit;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sreg <= '0;
      end else if (ce && advance) begin
         sreg <= {sreg[SCR_LEN-2:0], out_bit};
      end
   end
endmodule

// ### tsfoc_sig_mem.sv
`timescale 1ns/1ps
module tsfoc_sig_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 48,
   parameter int AW = 6
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      if (ce && wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rd_data <= '0;
      end else if (ce) begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule

// ### tsfoc_tx_ctrl.sv
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps
// Overview of operation
// - two 48-byte signaling stores: host-loaded input, muxer-read output
// - valid signaling bits per entry come from command register two
// - signaling bits are left aligned, first bit sent is entry msb
// - interrupt period 6, 3, 2 or 1 ms by update-rate field
// - whole input store copied to output at each load interrupt while test enable is clear
// - pointer reset write clears write pointer; entries then written in order
// - write pointer advances per buffer write, wraps after entry 48
// - pointer reset clears read pointer; reads step and wrap after 48
// - copy trigger write copies input to output only in test mode
// - test enable allows host copies and stops automatic copies
// - start delay from pcm frame to sync, field zero is one cycle
// - command bits 0 to 3 sampled per frame, used by that frame
// - force-ones replaces every payload bit with one
// - force-ones plus scrambler, no overhead, gives scrambled ones
// - scrambler covers all bits except sync word, tap from register two
module tsfoc_tx_ctrl #(
   parameter int FRAME_CYCLES_P = tsfoc_pkg::FRAME_CYCLES,
   parameter int FRAME_BITS = 4704,
   parameter logic [tsfoc_pkg::SYNC_LEN-1:0] SYNC_WORD = 14'h0F35
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [11:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic pcm_frame,
   input wire logic pay_bit,
   output logic pay_req,
   output logic tx_data,
   output logic tx_sync,
   output logic load_signaling_interrupt
);
   import tsfoc_pkg::*;

   localparam int SUB_W = $clog2(FRAME_CYCLES_P + 1);
   localparam int BIT_W = $clog2(FRAME_BITS + 1);

   function automatic logic [5:0] next_entry(input logic [5:0] p);
      return (p == 6'(SIG_DEPTH - 1)) ? 6'h00 : p + 6'h01;
   endfunction

   logic [7:0] start_delay, cmd_two, cmd_common;
   logic [5:0] cmd_one, cmd_act;
   logic [5:0] wr_ptr, rd_ptr, copy_idx, copy_widx;
   logic copy_req, copy_busy, copy_wv, copy_go;
   logic [7:0] in_rdata, out_rdata;
   logic [5:0] out_raddr;
   logic [9:0] idx;
   logic req, is_port, stall, bufrd, start_rd, rd_pend, wr_do;
   logic [31:0] rd_mux;
   logic pcm_s1, pcm_s2, pcm_s3, pcm_edge;
   logic [SUB_W-1:0] sub_cnt, sub_len;
   logic tick;
   tsfoc_state_type state;
   logic [7:0] dly_cnt;
   logic [BIT_W-1:0] bit_cnt;
   logic [4:0] seg;
   logic [5:0] sig_idx;
   logic [3:0] sig_bit, nsb;
   logic [5:0] crc_acc, crc_hold;
   logic raw_bit, scr_bit, sig_last;

   // ****************************************
   // wishbone slave
   // ****************************************
   assign idx = adr_i[11:2];
   assign req = cyc_i & stb_i & ~ack_o;
   assign is_port = (idx == IDX_SIG_PORT);
   assign stall = is_port & (copy_req | copy_busy | copy_wv | (~we_i & (state == ST_CRC | state == ST_SIG)));
   assign bufrd = req & is_port & ~we_i;
   assign start_rd = bufrd & ~rd_pend & ~stall;
   assign wr_do = cyc_i & stb_i & we_i & ack_o;

   always_comb begin
      case (idx)
         IDX_SIG_PORT: rd_mux = {24'h000000, out_rdata};
         IDX_START_DELAY: rd_mux = {24'h000000, start_delay};
         IDX_CMD_ONE: rd_mux = {26'h0000000, cmd_one};
         IDX_CMD_TWO: rd_mux = {24'h000000, cmd_two};
         IDX_CMD_COMMON: rd_mux = {24'h000000, cmd_common};
         IDX_TX_STATUS: rd_mux = {13'h0000, copy_busy, state, 3'h0, wr_ptr, rd_ptr};
         default: rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ack_o <= 1'b0;
         rd_pend <= 1'b0;
         dat_o <= 32'h00000000;
      end else if (ce) begin
         ack_o <= req & (bufrd ? rd_pend : ~stall);
         rd_pend <= start_rd;
         dat_o <= rd_mux;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         start_delay <= RST_START_DELAY;
         cmd_one <= RST_CMD_ONE;
         cmd_two <= RST_CMD_TWO;
         cmd_common <= RST_CMD_COMMON;
      end else if (ce && wr_do && sel_i[0]) begin
         case (idx)
            IDX_START_DELAY: start_delay <= dat_i[7:0];
            IDX_CMD_ONE: cmd_one <= dat_i[5:0];
            IDX_CMD_TWO: cmd_two <= dat_i[7:0];
            IDX_CMD_COMMON: cmd_common <= dat_i[7:0];
            default: ;
         endcase
      end
   end

   // ****************************************
   // signaling pointers and stores
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wr_ptr <= 6'h00;
         rd_ptr <= 6'h00;
      end else if (ce) begin
         if (wr_do && idx == IDX_PTR_RST) begin
            wr_ptr <= 6'h00;
            rd_ptr <= 6'h00;
         end else if (wr_do && is_port) begin
            wr_ptr <= next_entry(wr_ptr);
         end else if (cyc_i && stb_i && !we_i && ack_o && is_port) begin
            rd_ptr <= next_entry(rd_ptr);
         end
      end
   end

   // input store, loaded by the host
   tsfoc_sig_mem #(.WIDTH(8), .DEPTH(SIG_DEPTH), .AW(6)) u_in_store (
      .clk(clk),
      .rst_b(rst_b),
      .ce(ce),
      .wr_en(wr_do & is_port),
      .wr_addr(wr_ptr),
      .wr_data(dat_i[7:0]),
      .rd_addr(copy_idx),
      .rd_data(in_rdata)
   );

   // output store, read by the muxer and by host test reads
   tsfoc_sig_mem #(.WIDTH(8), .DEPTH(SIG_DEPTH), .AW(6)) u_out_store (
      .clk(clk),
      .rst_b(rst_b),
      .ce(ce),
      .wr_en(copy_wv),
      .wr_addr(copy_widx),
      .wr_data(in_rdata),
      .rd_addr(out_raddr),
      .rd_data(out_rdata)
   );

   // ****************************************
   // copy engine
   // ****************************************
   assign copy_go = (tick & ~cmd_one[CMD1_SIG_TEST])
      | (wr_do & (idx == IDX_COPY_TRIG) & cmd_one[CMD1_SIG_TEST]);

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         copy_req <= 1'b0;
         copy_busy <= 1'b0;
         copy_idx <= 6'h00;
      end else if (ce) begin
         if (copy_go) begin
            copy_req <= 1'b1;
         end else if (copy_req && !copy_busy && !(ack_o && is_port && we_i)) begin
            // a host write already acked lands before the copy starts
            copy_req <= 1'b0;
            copy_busy <= 1'b1;
            copy_idx <= 6'h00;
         end
         if (copy_busy) begin
            if (copy_idx == 6'(SIG_DEPTH - 1)) begin
               copy_busy <= 1'b0;
            end else begin
               copy_idx <= next_entry(copy_idx);
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         copy_wv <= 1'b0;
         copy_widx <= 6'h00;
      end else if (ce) begin
         copy_wv <= copy_busy;
         copy_widx <= copy_idx;
      end
   end

   // ****************************************
   // pcm frame sync and load interrupt timing
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pcm_s1 <= 1'b0;
         pcm_s2 <= 1'b0;
         pcm_s3 <= 1'b0;
      end else if (ce) begin
         pcm_s1 <= pcm_frame;
         pcm_s2 <= pcm_s1;
         pcm_s3 <= pcm_s2;
      end
   end
   assign pcm_edge = pcm_s2 & ~pcm_s3;

   always_comb begin
      case (cmd_common[COMMON_RATE_LSB +: 2])
         2'h1: sub_len = SUB_W'(FRAME_CYCLES_P / 2);
         2'h2: sub_len = SUB_W'(FRAME_CYCLES_P / 3);
         2'h3: sub_len = SUB_W'(FRAME_CYCLES_P / 6);
         default: sub_len = SUB_W'(FRAME_CYCLES_P);
      endcase
   end
   assign tick = pcm_edge | (sub_cnt == '0);

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sub_cnt <= SUB_W'(FRAME_CYCLES_P - 1);
         load_signaling_interrupt <= 1'b0;
      end else if (ce) begin
         sub_cnt <= tick ? sub_len - SUB_W'(1) : sub_cnt - SUB_W'(1);
         load_signaling_interrupt <= tick;
      end
   end

   // ****************************************
   // frame sequencer
   // ****************************************
   assign nsb = (cmd_two[CMD2_NSB_LSB +: 4] > 4'h8) ? 4'h8 : cmd_two[CMD2_NSB_LSB +: 4];
   assign sig_last = (sig_bit == nsb - 4'h1);
   assign out_raddr = start_rd ? rd_ptr : ((state == ST_SIG && sig_last) ? next_entry(sig_idx) : sig_idx);
   assign pay_req = (state == ST_PAY);

   always_comb begin
      case (state)
         ST_SYNC: raw_bit = SYNC_WORD[SYNC_LEN - 1 - seg];
         ST_CRC: raw_bit = cmd_act[CMD1_OVH_EN] ? (crc_hold[3'(CRC_LEN - 1) - seg[2:0]] ^ cmd_act[CMD1_CRC_INJ]) : 1'b1;
         ST_SIG: raw_bit = cmd_act[CMD1_OVH_EN] ? out_rdata[3'h7 - sig_bit[2:0]] : 1'b1;
         ST_PAY: raw_bit = cmd_act[CMD1_FORCE_ONES] | pay_bit;
         default: raw_bit = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state <= ST_IDLE;
         dly_cnt <= 8'h00;
         seg <= 5'h00;
         sig_idx <= 6'h00;
         sig_bit <= 4'h0;
         bit_cnt <= '0;
         cmd_act <= RST_CMD_ONE;
      end else if (ce) begin
         bit_cnt <= bit_cnt + BIT_W'(1);
         case (state)
            ST_IDLE: begin
               if (pcm_edge) begin
                  state <= ST_DELAY;
                  dly_cnt <= start_delay;
               end
            end
            ST_DELAY: begin
               dly_cnt <= dly_cnt - 8'h01;
               if (dly_cnt == 8'h00) begin
                  state <= ST_SYNC;
                  seg <= 5'h00;
                  bit_cnt <= '0;
                  cmd_act <= cmd_one;
               end
            end
            ST_SYNC: begin
               seg <= seg + 5'h01;
               if (seg == 5'(SYNC_LEN - 1)) begin
                  state <= ST_CRC;
                  seg <= 5'h00;
               end
            end
            ST_CRC: begin
               seg <= seg + 5'h01;
               sig_idx <= 6'h00;
               sig_bit <= 4'h0;
               if (seg == 5'(CRC_LEN - 1)) begin
                  state <= (nsb == 4'h0) ? ST_PAY : ST_SIG;
               end
            end
            ST_SIG: begin
               sig_bit <= sig_last ? 4'h0 : sig_bit + 4'h1;
               if (sig_last) begin
                  sig_idx <= next_entry(sig_idx);
                  if (sig_idx == 6'(SIG_DEPTH - 1)) begin
                     state <= ST_PAY;
                  end
               end
            end
            ST_PAY: begin
               if (bit_cnt >= BIT_W'(FRAME_BITS - 1)) begin
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // ****************************************
   // crc, scrambler and line output
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         crc_acc <= 6'h00;
         crc_hold <= 6'h00;
      end else if (ce) begin
         if (state == ST_SYNC) begin
            crc_acc <= 6'h00;
         end else if (state == ST_SIG || state == ST_PAY) begin
            crc_acc <= tsfoc_crc6(crc_acc, raw_bit);
         end
         if (state == ST_PAY && bit_cnt >= BIT_W'(FRAME_BITS - 1)) begin
            crc_hold <= tsfoc_crc6(crc_acc, raw_bit);
         end
      end
   end

   tsfoc_scrambler u_scrambler (
      .clk(clk),
      .rst_b(rst_b),
      .ce(ce),
      .advance(state == ST_CRC || state == ST_SIG || state == ST_PAY),
      .enable(cmd_act[CMD1_SCRAM]),
      .tap_sel(cmd_two[CMD2_TAP]),
      .in_bit(raw_bit),
      .out_bit(scr_bit)
   );

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         tx_data <= 1'b0;
         tx_sync <= 1'b0;
      end else if (ce) begin
         tx_data <= (state == ST_SYNC) ? raw_bit : (state != ST_IDLE && state != ST_DELAY) & scr_bit;
         tx_sync <= (state == ST_SYNC);
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b || !ce);

   AST_PTR_WRAP: assert property (wr_do && is_port && wr_ptr == 6'h2F |=> wr_ptr == 6'h00)
      else $error("write pointer did not wrap");
   AST_PTR_RST: assert property (wr_do && idx == IDX_PTR_RST |=> wr_ptr == 6'h00 && rd_ptr == 6'h00)
      else $error("pointer reset ignored");
   AST_COPY_LEN: assert property ($rose(copy_busy) |-> ##48 !copy_busy && copy_wv)
      else $error("copy length wrong");
   AST_TEST_COPY: assert property (wr_do && idx == IDX_COPY_TRIG && cmd_one[4] |=> copy_req || copy_busy)
      else $error("test copy not started");
   AST_NO_AUTO: assert property (cmd_one[4] && !copy_req && !(wr_do && idx == IDX_COPY_TRIG) |=> !copy_req)
      else $error("automatic copy in test mode");
   AST_DELAY: assert property (state == ST_IDLE && pcm_edge && start_delay == 8'h00 |=> state == ST_DELAY ##1 state == ST_SYNC)
      else $error("start delay wrong");
   AST_CMD_SAMPLE: assert property (state == ST_DELAY && dly_cnt == 8'h00 |=> cmd_act == $past(cmd_one))
      else $error("commands not sampled");
   AST_SYNC_BIT: assert property (state == ST_SYNC && seg == 5'h00 |=> tx_sync && tx_data == SYNC_WORD[13])
      else $error("sync word altered");
   AST_FORCE: assert property (state == ST_PAY && cmd_act[3] && !cmd_act[0] |=> tx_data)
      else $error("payload not forced");
   AST_CRC_INJ: assert property (state == ST_CRC && cmd_act[2:0] == 3'h6 |=> tx_data == !crc_hold[5 - $past(seg[2:0])])
      else $error("crc not inverted");
   AST_OVH_OFF: assert property (state == ST_SIG && !cmd_act[2] && !cmd_act[0] |=> tx_data)
      else $error("overhead not suppressed");

   COV_COPY: cover property ($fell(copy_busy));
   COV_FRAME: cover property (state == ST_PAY ##1 state == ST_IDLE);
   COV_BUFRD: cover property (rd_pend ##1 ack_o);
endmodule

// ### tsfoc_tx_ctrl_tb.sv
`timescale 1ns/1ps
module tsfoc_tx_ctrl_tb;
   import tsfoc_pkg::*;
   logic clk, rst_b, ce, cyc, stb, we, pcm_frame, pay_bit, pay_req, tx_data, tx_sync, irq, ack, fire, pq_d, pb_d;
   logic [11:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat;
   logic fb[200], sy[200], pq[200], pb[200];
   logic [13:0] sw, sw_ref;
   logic [5:0] crc, crc_ref;
   logic [7:0] rv;
   int n_mismatch, tests_run, lat, lat0, nsy, bad_pb, bad_one, c;

   tsfoc_tx_ctrl #(.FRAME_CYCLES_P(600), .FRAME_BITS(200)) u_tsfoc_tx_ctrl (.clk(clk), .rst_b(rst_b), .ce(ce),
      .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
      .pcm_frame(pcm_frame), .pay_bit(pay_bit), .pay_req(pay_req), .tx_data(tx_data), .tx_sync(tx_sync),
      .load_signaling_interrupt(irq));
   tsfoc_link_partner u_tsfoc_link_partner (.clk(clk), .rst_b(rst_b), .fire(fire), .pay_req(pay_req),
      .pcm_frame(pcm_frame), .pay_bit(pay_bit));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always_ff @(posedge clk) begin
      pq_d <= pay_req;
      pb_d <= pay_bit;
   end

   // ****************************************
   // checking and closing
   // ****************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #(4 * 60000);
      n_mismatch++;
      complete_run();
   end

   // ****************************************
   // wishbone classic master
   // ****************************************
   task automatic wb(input logic w, input logic [9:0] idx, input logic [7:0] wd, output logic [7:0] rd);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      wdat <= {24'h000000, wd};
      do @(posedge clk);
      while (ack !== 1'b1);
      rd = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      wb(1'b1, idx, d, rv);
   endtask
   task automatic rdc(input logic [9:0] idx, input logic [7:0] e);
      wb(1'b0, idx, 8'h00, rv);
      chk({8'h00, rv}, {8'h00, e});
   endtask
   function automatic logic [7:0] sval(input int i);
      return 8'(i * 37 + 5);
   endfunction
   task automatic wait_irq(output int n);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (irq !== 1'b1 && n < 3000);
   endtask

   // ****************************************
   // one frame: latency from pcm edge, captured bits
   // ****************************************
   task automatic frame;
      @(posedge clk);
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      lat = 1;
      while (tx_sync !== 1'b1 && lat < 2000) begin
         @(posedge clk);
         lat++;
      end
      nsy = 0;
      bad_pb = 0;
      bad_one = 0;
      for (int i = 0; i < 200; i++) begin
         fb[i] = tx_data;
         sy[i] = tx_sync;
         pq[i] = pq_d;
         pb[i] = pb_d;
         @(posedge clk);
      end
      for (int i = 0; i < 200; i++) begin
         if (sy[i] === 1'b1) nsy++;
         if (pq[i] === 1'b1 && fb[i] !== pb[i]) bad_pb++;
         if (pq[i] === 1'b1 && fb[i] !== 1'b1) bad_one++;
         if (i < 14) sw[13 - i] = fb[i];
         else if (i < 20) crc[19 - i] = fb[i];
      end
      repeat (30) @(posedge clk);
   endtask

   initial begin
      rst_b = 1'b0;
      ce = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 12'h000;
      sel = 4'hF;
      wdat = 32'h0;
      fire = 1'b0;
      n_mismatch = 0;
      tests_run = 0;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      rdc(IDX_START_DELAY, 8'h00);
      rdc(IDX_CMD_ONE, 8'h00);
      rdc(IDX_CMD_TWO, 8'h00);
      wr(10'h100, 8'h5A);
      rdc(10'h100, 8'h00);
      wr(IDX_START_DELAY, 8'hA5);
      rdc(IDX_START_DELAY, 8'hA5);
      wr(IDX_CMD_ONE, 8'hFF);
      rdc(IDX_CMD_ONE, 8'h3F);
      // host copy mode, 49 writes wrap onto entry one
      wr(IDX_CMD_ONE, 8'h10);
      wr(IDX_PTR_RST, 8'h00);
      for (int i = 0; i < 49; i++) wr(IDX_SIG_PORT, sval(i));
      wr(IDX_COPY_TRIG, 8'h00);
      wr(IDX_PTR_RST, 8'h00);
      for (int i = 0; i < 49; i++) rdc(IDX_SIG_PORT, sval((i % 48 == 0) ? 48 : i));
      // no automatic copy while in test mode
      wr(IDX_PTR_RST, 8'h00);
      for (int i = 0; i < 48; i++) wr(IDX_SIG_PORT, sval(i + 100));
      wait_irq(c);
      repeat (80) @(posedge clk);
      wr(IDX_PTR_RST, 8'h00);
      rdc(IDX_SIG_PORT, sval(48));
      wr(IDX_COPY_TRIG, 8'h00);
      wr(IDX_PTR_RST, 8'h00);
      rdc(IDX_SIG_PORT, sval(100));
      // normal mode: interrupt copies the input store
      wr(IDX_CMD_ONE, 8'h00);
      wr(IDX_COPY_TRIG, 8'h00);
      wr(IDX_PTR_RST, 8'h00);
      for (int i = 0; i < 48; i++) wr(IDX_SIG_PORT, sval(i + 200));
      wait_irq(c);
      repeat (80) @(posedge clk);
      wr(IDX_PTR_RST, 8'h00);
      rdc(IDX_SIG_PORT, sval(200));
      rdc(IDX_SIG_PORT, sval(201));
      // interrupt period for each update rate
      for (int r = 0; r < 4; r++) begin
         wr(IDX_CMD_COMMON, 8'(r << COMMON_RATE_LSB));
         wait_irq(c);
         wait_irq(c);
         wait_irq(c);
         chk(16'(c), 16'(600 / ((r == 0) ? 1 : (r == 1) ? 2 : (r == 2) ? 3 : 6)));
      end
      // clock enable low freezes the interrupt timer
      ce <= 1'b0;
      c = 0;
      repeat (300) begin
         @(posedge clk);
         if (irq !== 1'b0) c++;
      end
      ce <= 1'b1;
      chk(16'(c), 16'h0000);
      wait_irq(c);
      chk(16'(c), 16'(600 / 6));
      wr(IDX_CMD_COMMON, 8'h00);
      // frames, no signaling bits
      wr(IDX_CMD_TWO, 8'h00);
      wr(IDX_START_DELAY, 8'h00);
      wr(IDX_CMD_ONE, 8'h04);
      frame();
      lat0 = lat;
      sw_ref = sw;
      chk(16'(nsy), 16'(SYNC_LEN));
      chk(16'(bad_pb), 16'h0000);
      frame();
      crc_ref = crc;
      wr(IDX_START_DELAY, 8'h09);
      frame();
      chk(16'(lat), 16'(lat0 + 9));
      chk({10'h000, crc}, {10'h000, crc_ref});
      wr(IDX_CMD_ONE, 8'h06);
      frame();
      chk({10'h000, crc}, {10'h000, ~crc_ref});
      wr(IDX_CMD_ONE, 8'h0C);
      frame();
      chk(16'(bad_one), 16'h0000);
      wr(IDX_CMD_ONE, 8'h00);
      frame();
      chk({10'h000, crc}, 16'h003F);
      chk({2'b00, sw}, {2'b00, sw_ref});
      wr(IDX_CMD_ONE, 8'h09);
      frame();
      chk({2'b00, sw}, {2'b00, sw_ref});
      chk(16'(nsy), 16'(SYNC_LEN));
      chk(16'(bad_one != 0), 16'h0001);
      // three signaling bits per entry, left aligned, msb first
      wr(IDX_CMD_TWO, 8'h0C);
      wr(IDX_CMD_ONE, 8'h04);
      frame();
      for (int k = 0; k < 48; k++) begin
         rv = sval(k + 200);
         chk({13'h0000, fb[20 + 3 * k], fb[21 + 3 * k], fb[22 + 3 * k]}, {13'h0000, rv[7:5]});
      end
      wr(IDX_CMD_ONE, 8'h00);
      frame();
      c = 0;
      for (int i = 14; i < 164; i++) if (fb[i] !== 1'b1) c++;
      chk(16'(c), 16'h0000);
      complete_run();
   end
endmodule
